// ===== scb_regs.svh
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH

// ******************************
// register addresses (7-bit)
// ******************************
`define SCB_ADDR_PART   7'h00
`define SCB_ADDR_FWCFG  7'h39
`define SCB_ADDR_SRST   7'h3A
`define SCB_ADDR_PDN    7'h3B
`define SCB_ADDR_INVPC  7'h3F
`define SCB_ADDR_MBURST 7'h50
`define SCB_ADDR_FWSTR  7'h62
`define SCB_ADDR_PIX    7'h64

// ******************************
// command values, fields, resets
// ******************************
`define SCB_CMD_SRST     8'h5A
`define SCB_CMD_PDN      8'hB6
`define SCB_FWCFG_RST    8'h00
`define SCB_FWCFG_SEL    1
`define SCB_RDATA_RST    8'h00
// part code value is arbitrary
`define SCB_PART_CODE    8'h3E

// ******************************
// sizes and counts
// ******************************
`define SCB_FW_SMALL     12'h600
`define SCB_FW_LARGE     12'hC00
`define SCB_FW_DEPTH     3072
`define SCB_PIX_DEPTH    900
`define SCB_PIX_LAST     10'h383
`define SCB_MB_LAST      4'hD
`define SCB_MB_BITS      112

`endif

// ===== scb_pkg.sv
package scb_pkg;

  // read sequencer of the register core
  typedef enum logic [0:0] {
    SCB_IDLE  = 1'b0,
    SCB_FETCH = 1'b1
  } scb_state_t;

  typedef logic [7:0] scb_byte_t;
  typedef logic [6:0] scb_addr_t;

endpackage

// ===== scb_mem.sv
`timescale 1ns/10ps
`default_nettype none

// ******************************
// one write, one registered read
// ******************************
module scb_mem #(
  parameter int DEPTH = 900,
  parameter int AW    = 10
) (
  input  wire logic          clock,
  input  wire logic          wen,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata_r
);

  logic [7:0] mem [DEPTH];

  // contents survive resets; only pointers are cleared
  always_ff @(posedge clock) begin
    if (wen) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end

endmodule

`default_nettype wire

// ===== scb_link.sv
`timescale 1ns/10ps
`default_nettype none

// ******************************
// serial port slave, sclk domain
// ******************************
module scb_link (
  input  wire logic                 sclk,
  input  wire logic                 ncs,
  input  wire logic                 mosi,
  input  wire logic                 rst,
  input  wire scb_pkg::scb_byte_t   rd_data,
  output logic                      miso,
  output logic                      miso_oe,
  output logic                      req_tog,
  output scb_pkg::scb_addr_t        req_addr,
  output logic                      req_wr,
  output logic                      req_first,
  output scb_pkg::scb_byte_t        req_wdata
);

  logic [2:0]         cnt_r, cnt_nxt;
  logic [6:0]         sh_r, sh_nxt;
  logic               have_addr_r, have_addr_nxt;
  logic               seen_r, seen_nxt;
  logic               tog_nxt, wr_nxt, first_nxt;
  scb_pkg::scb_addr_t addr_nxt;
  scb_pkg::scb_byte_t wdata_nxt, rx_byte;
  logic [6:0]         out_r, out_nxt;
  logic               miso_nxt, oe_nxt, rd_phase;

  assign rx_byte  = {sh_r, mosi};
  assign rd_phase = have_addr_r && !req_wr;

  // byte assembly, address phase, request toggles
  always_comb begin
    cnt_nxt       = cnt_r + 3'h1;
    sh_nxt        = {sh_r[5:0], mosi};
    have_addr_nxt = have_addr_r;
    seen_nxt      = seen_r;
    tog_nxt       = req_tog;
    addr_nxt      = req_addr;
    wr_nxt        = req_wr;
    first_nxt     = req_first;
    wdata_nxt     = req_wdata;
    if (!have_addr_r) begin
      if (cnt_r == 3'h7) begin
        have_addr_nxt = 1'b1;
        addr_nxt      = rx_byte[6:0];
        wr_nxt        = rx_byte[7];
        if (!rx_byte[7]) begin
          first_nxt = 1'b1;
          tog_nxt   = ~req_tog;
        end
      end
    end else if (req_wr) begin
      if (cnt_r == 3'h7) begin
        wdata_nxt = rx_byte;
        first_nxt = !seen_r;
        seen_nxt  = 1'b1;
        tog_nxt   = ~req_tog;
      end
    end else if (cnt_r == 3'h0) begin
      // prefetch the next byte while this one shifts out
      first_nxt = 1'b0;
      tog_nxt   = ~req_tog;
    end
  end

  // frame state ends with the frame itself
  always_ff @(posedge sclk or posedge ncs) begin
    if (ncs) begin
      cnt_r       <= 3'h0;
      sh_r        <= 7'h00;
      have_addr_r <= 1'b0;
      seen_r      <= 1'b0;
    end else begin
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      have_addr_r <= have_addr_nxt;
      seen_r      <= seen_nxt;
    end
  end

  // payload outlives the frame so a last write is not cut off
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      req_tog   <= 1'b0;
      req_addr  <= 7'h00;
      req_wr    <= 1'b0;
      req_first <= 1'b0;
      req_wdata <= 8'h00;
    end else begin
      req_tog   <= tog_nxt;
      req_addr  <= addr_nxt;
      req_wr    <= wr_nxt;
      req_first <= first_nxt;
      req_wdata <= wdata_nxt;
    end
  end

  // output shifter; rd_data is steady by the host's read wait
  always_comb begin
    out_nxt  = out_r;
    miso_nxt = miso;
    oe_nxt   = rd_phase;
    if (rd_phase) begin
      if (cnt_r == 3'h0) begin
        miso_nxt = rd_data[7];
        out_nxt  = rd_data[6:0];
      end else begin
        miso_nxt = out_r[6];
        out_nxt  = {out_r[5:0], 1'b0};
      end
    end
  end

  // data changes on falling edges, host samples on rising
  always_ff @(negedge sclk or posedge ncs) begin
    if (ncs) begin
      out_r   <= 7'h00;
      miso    <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      out_r   <= out_nxt;
      miso    <= miso_nxt;
      miso_oe <= oe_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== scb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "scb_regs.svh"

// Summary of operation
// R1: size bit one: clear 1.5K, set 3K
// R2: host sets size before any download
// R3: 0x5A to 0x3A resets all settings
// R4: host resets to leave power-down, capture
// R5: 0xB6 to 0x3B enters power-down
// R6: 0x3F reads complement of part code
// R7: 0x50 streams motion bytes in order
// R8: any write to 0x50 clears burst data; a write during power-down is ignored and clears nothing
// R9: 0x62 takes consecutive firmware bytes
// R10: 0x64 reads advance pixel pointer, 900
// R11: firmware config reserved bits read zero
module scb_top (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      sclk,
  input  wire logic                      ncs,
  input  wire logic                      mosi,
  output logic                           miso,
  output logic                           miso_oe,
  input  wire logic [`SCB_MB_BITS-1:0]   burst_src,
  input  wire logic                      pix_valid,
  input  wire logic [7:0]                pix_data,
  output logic                           power_down,
  output logic                           fw_size_select,
  output logic                           fw_load_done
);

  // ******************************
  // declarations
  // ******************************
  logic                      req_tog, req_wr, req_first;
  scb_pkg::scb_addr_t        req_addr;
  scb_pkg::scb_byte_t        req_wdata;
  logic [2:0]                tq_r, tq_nxt;
  logic                      tlvl_r, tlvl_nxt;
  logic                      ev, wr_ev, rd_ev, srst;
  logic                      srst_r, srst_nxt;
  scb_pkg::scb_state_t       st_r, st_nxt;
  scb_pkg::scb_addr_t        rsel_r, rsel_nxt;
  scb_pkg::scb_byte_t        rd_data_r, rd_data_nxt;
  scb_pkg::scb_byte_t        cfg_r, cfg_nxt;
  logic                      pd_r, pd_nxt;
  logic [3:0]                mb_idx_r, mb_idx_nxt;
  logic [`SCB_MB_BITS-1:0]   snap_r, snap_nxt;
  logic [9:0]                prd_r, prd_nxt;
  logic [9:0]                pwr_r, pwr_nxt;
  logic [11:0]               fw_ptr_r, fw_ptr_nxt, fw_lim;
  logic [11:0]               fw_waddr;
  logic                      fw_done_r, fw_done_nxt, fw_wen;
  scb_pkg::scb_byte_t        pix_rdata;

  // ******************************
  // link side and memories
  // ******************************
  scb_link u_link (
    .sclk      (sclk),
    .ncs       (ncs),
    .mosi      (mosi),
    .rst       (rst),
    .rd_data   (rd_data_r),
    .miso      (miso),
    .miso_oe   (miso_oe),
    .req_tog   (req_tog),
    .req_addr  (req_addr),
    .req_wr    (req_wr),
    .req_first (req_first),
    .req_wdata (req_wdata)
  );

  scb_mem #(.DEPTH(`SCB_FW_DEPTH), .AW(12)) u_fw_mem (
    .clock   (clock),
    .wen     (fw_wen),
    .waddr   (fw_waddr),
    .wdata   (req_wdata),
    .raddr   (12'h000),
    .rdata_r ()
  );

  scb_mem #(.DEPTH(`SCB_PIX_DEPTH), .AW(10)) u_pix_mem (
    .clock   (clock),
    .wen     (pix_valid && !pd_r),
    .waddr   (pwr_r),
    .wdata   (pix_data),
    .raddr   (prd_nxt),
    .rdata_r (pix_rdata)
  );

  // ******************************
  // request crossing
  // ******************************
  // three stages; a change counts once stages two and three agree
  always_comb begin
    tq_nxt   = {tq_r[1:0], req_tog};
    tlvl_nxt = (tq_r[1] == tq_r[2]) ? tq_r[2] : tlvl_r;
  end

  assign ev    = tlvl_nxt != tlvl_r;
  assign wr_ev = ev && req_wr;
  assign rd_ev = ev && !req_wr;
  // soft reset acts one cycle after the command lands
  assign srst  = rst || srst_r;

  // crossing state follows only the pin reset, never a soft one
  always_ff @(posedge clock) begin
    if (rst) begin
      tq_r   <= 3'h0;
      tlvl_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      tq_r   <= tq_nxt;
      tlvl_r <= tlvl_nxt;
      srst_r <= srst_nxt;
    end
  end

  // ******************************
  // register core
  // ******************************
  assign fw_lim = cfg_r[`SCB_FWCFG_SEL] ? `SCB_FW_LARGE : `SCB_FW_SMALL; // R1

  // writes, burst pointers and read sequencing
  always_comb begin
    srst_nxt    = wr_ev && req_addr == `SCB_ADDR_SRST
                  && req_wdata == `SCB_CMD_SRST; // R3
    st_nxt      = st_r;
    rsel_nxt    = rsel_r;
    rd_data_nxt = rd_data_r;
    cfg_nxt     = cfg_r;
    pd_nxt      = pd_r;
    mb_idx_nxt  = mb_idx_r;
    snap_nxt    = snap_r;
    prd_nxt     = prd_r;
    pwr_nxt     = pwr_r;
    fw_ptr_nxt  = fw_ptr_r;
    fw_done_nxt = fw_done_r;
    fw_wen      = 1'b0;
    fw_waddr    = fw_ptr_r;
    // power-down blocks every write but the reset command
    if (wr_ev && !pd_r) begin
      if (req_addr == `SCB_ADDR_FWCFG) begin
        cfg_nxt = `SCB_FWCFG_RST; // R11
        cfg_nxt[`SCB_FWCFG_SEL] = req_wdata[`SCB_FWCFG_SEL]; // R1
      end else if (req_addr == `SCB_ADDR_PDN) begin
        pd_nxt = req_wdata == `SCB_CMD_PDN; // R5
      end else if (req_addr == `SCB_ADDR_MBURST) begin
        mb_idx_nxt = 4'h0; // R8
        snap_nxt   = '0; // R8
      end else if (req_addr == `SCB_ADDR_FWSTR) begin
        // R9
        if (req_first) begin
          fw_wen      = 1'b1;
          fw_waddr    = 12'h000;
          fw_ptr_nxt  = 12'h001;
          fw_done_nxt = 1'b0;
        end else if (fw_ptr_r < fw_lim) begin
          fw_wen      = 1'b1;
          fw_ptr_nxt  = fw_ptr_r + 12'h001;
          fw_done_nxt = fw_ptr_nxt == fw_lim;
        end
      end
    end
    if (rd_ev) begin
      st_nxt   = scb_pkg::SCB_FETCH;
      rsel_nxt = req_addr;
      if (req_addr == `SCB_ADDR_MBURST) begin
        // R7
        if (req_first) begin
          snap_nxt   = burst_src;
          mb_idx_nxt = 4'h0;
        end else if (mb_idx_r != `SCB_MB_LAST) begin
          mb_idx_nxt = mb_idx_r + 4'h1;
        end
      end else if (req_addr == `SCB_ADDR_PIX && !req_first) begin
        // the byte shifting out now was read, so move on
        prd_nxt = (prd_r == `SCB_PIX_LAST) ? 10'h000
                  : prd_r + 10'h001; // R10
      end
    end
    if (st_r == scb_pkg::SCB_FETCH) begin
      st_nxt = scb_pkg::SCB_IDLE;
      if (rsel_r == `SCB_ADDR_FWCFG) begin
        rd_data_nxt = cfg_r;
      end else if (rsel_r == `SCB_ADDR_INVPC) begin
        rd_data_nxt = ~`SCB_PART_CODE; // R6
      end else if (rsel_r == `SCB_ADDR_PART) begin
        rd_data_nxt = `SCB_PART_CODE;
      end else if (rsel_r == `SCB_ADDR_MBURST) begin
        rd_data_nxt = snap_r[{mb_idx_r, 3'h0} +: 8]; // R7
      end else if (rsel_r == `SCB_ADDR_PIX) begin
        rd_data_nxt = pix_rdata; // R10
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
    // frame capture fills the pixel store in order
    if (pix_valid && !pd_r) begin
      pwr_nxt = (pwr_r == `SCB_PIX_LAST) ? 10'h000 : pwr_r + 10'h001;
    end
  end

  // every setting returns to default on either reset
  always_ff @(posedge clock) begin
    if (srst) begin // R3
      st_r      <= scb_pkg::SCB_IDLE;
      rsel_r    <= 7'h00;
      rd_data_r <= `SCB_RDATA_RST;
      cfg_r     <= `SCB_FWCFG_RST;
      pd_r      <= 1'b0;
      mb_idx_r  <= 4'h0;
      snap_r    <= '0;
      prd_r     <= 10'h000;
      pwr_r     <= 10'h000;
      fw_ptr_r  <= 12'h000;
      fw_done_r <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      rsel_r    <= rsel_nxt;
      rd_data_r <= rd_data_nxt;
      cfg_r     <= cfg_nxt;
      pd_r      <= pd_nxt;
      mb_idx_r  <= mb_idx_nxt;
      snap_r    <= snap_nxt;
      prd_r     <= prd_nxt;
      pwr_r     <= pwr_nxt;
      fw_ptr_r  <= fw_ptr_nxt;
      fw_done_r <= fw_done_nxt;
    end
  end

  // outputs straight from flops
  assign power_down     = pd_r;
  assign fw_size_select = cfg_r[`SCB_FWCFG_SEL];
  assign fw_load_done   = fw_done_r;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_soft_reset_cmd: assert property ( // R3
    srst_nxt |=> ##1 (!power_down && cfg_r == `SCB_FWCFG_RST
                      && fw_ptr_r == 12'h000))
    else $error("soft reset did not restore defaults");

  a_pd_enter_cmd: assert property ( // R5
    wr_ev && !pd_r && req_addr == `SCB_ADDR_PDN
    && req_wdata == `SCB_CMD_PDN |=> power_down)
    else $error("power-down command not taken");

  a_pd_only_reset: assert property ( // R4
    power_down && !srst_nxt && !srst_r |=> power_down)
    else $error("power-down left without reset command");

  a_size_sel_write: assert property ( // R1
    wr_ev && !pd_r && req_addr == `SCB_ADDR_FWCFG |=>
    fw_size_select == $past(req_wdata[1]))
    else $error("firmware size select not written");

  a_cfg_reserved_zero: assert property ( // R11
    cfg_r[7:2] == 6'h00 && !cfg_r[0])
    else $error("reserved config bits set");

  a_inv_code_read: assert property ( // R6
    rd_ev && req_addr == `SCB_ADDR_INVPC |-> ##2
    rd_data_r == ~`SCB_PART_CODE)
    else $error("complement part code wrong");

  a_burst_wr_clear: assert property ( // R8
    wr_ev && !pd_r && req_addr == `SCB_ADDR_MBURST && !srst_r |=>
    (snap_r == '0 && mb_idx_r == 4'h0))
    else $error("burst write did not clear data");

  a_burst_step_next: assert property ( // R7
    rd_ev && req_addr == `SCB_ADDR_MBURST && !req_first
    && mb_idx_r != `SCB_MB_LAST && !srst_r |=>
    mb_idx_r == $past(mb_idx_r) + 4'h1)
    else $error("motion burst index did not step");

  a_pix_ptr_step: assert property ( // R10
    rd_ev && req_addr == `SCB_ADDR_PIX && !req_first && !srst_r |=>
    prd_r == (($past(prd_r) == `SCB_PIX_LAST) ? 10'h000
              : $past(prd_r) + 10'h001))
    else $error("pixel pointer did not advance");

  a_fw_done_count: assert property ( // R9
    $rose(fw_load_done) |-> fw_ptr_r == fw_lim)
    else $error("firmware done at wrong count");

  c_soft_reset: cover property (srst_r);
  c_power_down: cover property ($rose(power_down));
  c_pix_wrap: cover property (prd_r == `SCB_PIX_LAST ##[1:200] prd_r == 10'h000);
  c_fw_done: cover property ($rose(fw_load_done));

endmodule

`default_nettype wire

// ===== scb_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ******************************
// host controller on serial port
// ******************************
module scb_host_model (
  output logic      sclk,
  output logic      ncs,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  localparam realtime HALF = 62.5;

  scb_pkg::scb_byte_t rx_buf [0:1023];
  int                 sent;
  logic               oe_ok;

  // link clock stands high outside frames
  initial begin
    sclk  = 1'b1;
    ncs   = 1'b1;
    mosi  = 1'b0;
    sent  = 0;
    oe_ok = 1'b1;
  end

  // msb first: drive after the fall, sample at the rise
  task automatic xfer(input scb_pkg::scb_byte_t tx, input logic rd,
                      output scb_pkg::scb_byte_t rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      #(HALF);
      sclk  = 1'b1;
      rx[i] = miso;
      if (rd && (miso_oe !== 1'b1)) oe_ok = 1'b0;
      #(HALF);
    end
  endtask

  // close a frame; gap lets the core finish the last byte
  task automatic frame_close();
    #(HALF);
    ncs  = 1'b1;
    mosi = ~mosi;
    #600;
  endtask

  // address byte then n data bytes, fixed or counting pattern
  task automatic write_n(input scb_pkg::scb_addr_t a, input int n,
                         input scb_pkg::scb_byte_t d, input logic seq);
    scb_pkg::scb_byte_t junk;
    ncs = 1'b0;
    #(HALF);
    xfer({1'b1, a}, 1'b0, junk);
    sent = 0;
    for (int k = 0; k < n; k++) begin
      xfer(seq ? 8'(k * 5 + 1) : d, 1'b0, junk);
      sent = k + 1;
    end
    frame_close();
  endtask

  // read burst; the wait covers the core's fetch of byte one
  task automatic read_n(input scb_pkg::scb_addr_t a, input int n);
    scb_pkg::scb_byte_t junk;
    ncs = 1'b0;
    #(HALF);
    xfer({1'b0, a}, 1'b0, junk);
    #400;
    for (int k = 0; k < n; k++) begin
      xfer(8'(k ^ 8'hA5), 1'b1, rx_buf[k]);
    end
    frame_close();
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "scb_regs.svh"

`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module testbench;
  logic                    clock;
  logic                    rst;
  logic                    sclk;
  logic                    ncs;
  logic                    mosi;
  logic                    miso;
  logic                    miso_oe;
  logic [`SCB_MB_BITS-1:0] burst_src;
  logic                    pix_valid;
  logic [7:0]              pix_data;
  logic                    power_down;
  logic                    fw_size_select;
  logic                    fw_load_done;
  int                      fails;
  int                      checks_done;

  // ******************************
  // design, host model, clock
  // ******************************
  scb_top DUT (.clock(clock), .rst(rst), .sclk(sclk), .ncs(ncs),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .burst_src(burst_src),
    .pix_valid(pix_valid), .pix_data(pix_data), .power_down(power_down),
    .fw_size_select(fw_size_select), .fw_load_done(fw_load_done));

  scb_host_model host (.sclk(sclk), .ncs(ncs), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe));

  // core clock 25 MHz
  initial clock = 1'b0;
  always #20 clock = ~clock;

  // ******************************
  // helpers
  // ******************************
  function automatic logic [7:0] px(input int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.write_n(a, 1, d, 1'b0);
  endtask

  task automatic rd(input logic [6:0] a);
    host.read_n(a, 1);
  endtask

  // byte k of the motion source is s plus three per step
  task automatic load_burst(input logic [7:0] s);
    for (int k = 0; k < 14; k++) burst_src[8*k +: 8] = 8'(s + k * 3);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ******************************
  // scenarios
  // ******************************
  task automatic t_reset();
    `CHK(power_down, 1'b0)
    `CHK(fw_size_select, 1'b0)
    `CHK(fw_load_done, 1'b0)
    rd(`SCB_ADDR_FWCFG);
    `CHK(host.rx_buf[0], `SCB_FWCFG_RST)
  endtask

  task automatic t_config();
    wr(`SCB_ADDR_FWCFG, 8'hFF);
    `CHK(fw_size_select, 1'b1)
    rd(`SCB_ADDR_FWCFG);
    `CHK(host.rx_buf[0], 8'h02)
    wr(`SCB_ADDR_FWCFG, 8'hFD);
    `CHK(fw_size_select, 1'b0)
    rd(`SCB_ADDR_FWCFG);
    `CHK(host.rx_buf[0], 8'h00)
  endtask

  task automatic t_part();
    wr(`SCB_ADDR_INVPC, 8'h00);
    rd(`SCB_ADDR_INVPC);
    `CHK(host.rx_buf[0], ~`SCB_PART_CODE)
    rd(`SCB_ADDR_PART);
    `CHK(host.rx_buf[0], `SCB_PART_CODE)
    `CHK(host.oe_ok, 1'b1)
    `CHK(miso_oe, 1'b0)
    rd(7'h01);
    `CHK(host.rx_buf[0], 8'h00)
  endtask

  // bytes past the fourteenth repeat the last one
  task automatic t_motion();
    load_burst(8'h20);
    host.read_n(`SCB_ADDR_MBURST, 15);
    for (int k = 0; k < 15; k++)
      `CHK(host.rx_buf[k], 8'(8'h20 + (k > 13 ? 13 : k) * 3))
    wr(`SCB_ADDR_MBURST, 8'h77);
    load_burst(8'h90);
    host.read_n(`SCB_ADDR_MBURST, 2);
    `CHK(host.rx_buf[0], 8'h90)
    `CHK(host.rx_buf[1], 8'h93)
  endtask

  task automatic t_firmware();
    wr(`SCB_ADDR_FWCFG, 8'h00);
    fork
      host.write_n(`SCB_ADDR_FWSTR, 1536, 8'h00, 1'b1);
    join_none
    wait (host.sent == 1535);
    cyc(10);
    `CHK(fw_load_done, 1'b0)
    wait fork;
    cyc(2);
    `CHK(fw_load_done, 1'b1)
    wr(`SCB_ADDR_FWCFG, 8'h02);
    host.write_n(`SCB_ADDR_FWSTR, 8, 8'h00, 1'b1);
    `CHK(fw_load_done, 1'b0)
  endtask

  // a full frame, then two more reads that wrap to the start
  task automatic t_pixel();
    cyc(1);
    for (int i = 0; i < `SCB_PIX_DEPTH; i++) begin
      pix_valid = 1'b1;
      pix_data  = px(i);
      cyc(1);
    end
    pix_valid = 1'b0;
    cyc(2);
    host.read_n(`SCB_ADDR_PIX, `SCB_PIX_DEPTH);
    for (int i = 0; i < `SCB_PIX_DEPTH; i++)
      `CHK(host.rx_buf[i], px(i))
    host.read_n(`SCB_ADDR_PIX, 2);
    `CHK(host.rx_buf[0], px(0))
    `CHK(host.rx_buf[1], px(1))
  endtask

  task automatic t_power();
    wr(`SCB_ADDR_PDN, 8'hB5);
    `CHK(power_down, 1'b0)
    wr(`SCB_ADDR_PDN, `SCB_CMD_PDN);
    `CHK(power_down, 1'b1)
    wr(`SCB_ADDR_FWCFG, 8'h00);
    `CHK(fw_size_select, 1'b1)
    rd(`SCB_ADDR_INVPC);
    `CHK(host.rx_buf[0], ~`SCB_PART_CODE)
    wr(`SCB_ADDR_SRST, 8'h5B);
    `CHK(power_down, 1'b1)
    wr(`SCB_ADDR_SRST, `SCB_CMD_SRST);
    `CHK(power_down, 1'b0)
    `CHK(fw_size_select, 1'b0)
    rd(`SCB_ADDR_FWCFG);
    `CHK(host.rx_buf[0], `SCB_FWCFG_RST)
    rd(`SCB_ADDR_PIX);
    `CHK(host.rx_buf[0], px(0))
  endtask

  // ******************************
  // main sequence and watchdog
  // ******************************
  initial begin
    rst         = 1'b1;
    burst_src   = '0;
    pix_valid   = 1'b0;
    pix_data    = 8'h00;
    fails       = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    cyc(2);
    t_reset();
    t_config();
    t_part();
    t_motion();
    t_firmware();
    t_pixel();
    t_power();
    final_report();
  end

  // whole run needs under 3 ms of link traffic
  initial begin
    #4_000_000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
